// file: core/tw_port.sv
`timescale 1ns/1ps
module tw_port
    import tw_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clk_link_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    output logic [7:0] sfr_rdata_o,
    output logic irq_o,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Processor-side declarations
    tw_cfg_t cfg_reg;
    tw_status_t status_w;
    logic [7:0] txd_reg;
    logic [7:0] rxd_reg;
    logic tx_req_tgl_reg;
    logic stop_seen_reg;
    logic nack_seen_reg;
    logic rx_ov_reg;
    logic rx_av_reg;
    logic tx_emp_reg;
    logic irq_reg;
    logic [7:0] rdata_reg;
    logic sda_lvl_s;
    logic [1:0] lvl_s;
    logic [4:0] ev_p;

    // Link-side declarations
    logic link_rst_n;
    logic [1:0] pin_s;
    logic [8:0] cfg_tx_s;
    tw_cfg_t cfg_l;
    tw_state_t state_reg;
    logic [3:0] bitcnt_reg;
    logic [7:0] shreg_reg;
    logic [7:0] rxb_reg;
    logic [7:0] cnt_reg;
    logic dir_tx_reg;
    logic addr_ph_reg;
    logic rw_reg;
    logic stop_lat_reg;
    logic scl_oe_reg;
    logic sda_oe_reg;
    logic scl_d_reg;
    logic sda_d_reg;
    logic idle_reg;
    logic ackph_reg;
    logic low_reg;
    logic take_tgl_reg;
    logic rx_tgl_reg;
    logic start_tgl_reg;
    logic stop_tgl_reg;
    logic nack_tgl_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock-domain crossings
    tw_sync #(.W(1)) u_link_rst (
        .clk_i(clk_link_i),
        .arst_n_i(arst_n_i),
        .d_i(1'b1),
        .q_o(link_rst_n)
    );

    // Bus pins into the link domain, inverted so reset matches an idle pulled-up bus
    tw_sync #(.W(2)) u_pin_sync (
        .clk_i(clk_link_i),
        .arst_n_i(link_rst_n),
        .d_i({!scl_i, !sda_i}),
        .q_o(pin_s)
    );

    // Configuration is quasi-static; transmit request is a toggle
    tw_sync #(.W(9)) u_cfg_sync (
        .clk_i(clk_link_i),
        .arst_n_i(link_rst_n),
        .d_i({cfg_reg, tx_req_tgl_reg}),
        .q_o(cfg_tx_s)
    );

    // Data line level for the status register
    tw_sync #(.W(1)) u_sda_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i(sda_i),
        .q_o(sda_lvl_s)
    );

    // Engine levels back to the processor side
    tw_sync #(.W(2)) u_lvl_sync (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .d_i({idle_reg, ackph_reg}),
        .q_o(lvl_s)
    );

    // Engine events: rx, take, start, stop, nack
    tw_evt #(.W(5)) u_evt (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tgl_i({rx_tgl_reg, take_tgl_reg, start_tgl_reg, stop_tgl_reg, nack_tgl_reg}),
        .pulse_o(ev_p)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Link-side decode
    wire logic scl_s = !pin_s[1];
    wire logic sda_s = !pin_s[0];
    wire logic ctl_w = cfg_l.controller_role_select;
    wire logic tx_pend_w = cfg_tx_s[0] ^ take_tgl_reg;
    wire logic tick_w = cnt_reg == (TW_HALF_CYC - 8'h01);
    wire logic rise_w = ctl_w ? (tick_w && scl_oe_reg) : (scl_s && !scl_d_reg);
    wire logic fall_w = ctl_w ? (tick_w && !scl_oe_reg) : (!scl_s && scl_d_reg);
    wire logic bus_start_w = !ctl_w && scl_s && scl_d_reg && sda_d_reg && !sda_s;
    wire logic bus_stop_w = !ctl_w && scl_s && scl_d_reg && !sda_d_reg && sda_s;
    wire logic ack_bit_w = bitcnt_reg == TW_ACK_BIT;
    wire logic nack_w = dir_tx_reg && sda_s;
    wire logic addr_hit_w = shreg_reg[7:1] == TW_OWN_ID;
    wire logic next_tx_w = ctl_w ? !rw_reg : shreg_reg[0];
    wire logic [7:0] rx_byte_w = {shreg_reg[6:0], sda_s};
    // Stop request forces a not-acknowledge so the far end releases the line
    wire logic auto_ack_w = !(ctl_w && stop_lat_reg);
    wire logic data_ack_w = cfg_l.manual_ack_enable ? cfg_l.ack_level_select : auto_ack_w;
    wire logic ack_low_w = addr_ph_reg ? addr_hit_w : data_ack_w;
    wire logic [7:0] link_txd_w = txd_reg;

    assign cfg_l = cfg_tx_s[8:1];

    ////////////////////////////////////////////////////////////////////////////
    // Link-side housekeeping: edges, half-period counter, status levels
    always_ff @(posedge clk_link_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
            cnt_reg <= 8'h00;
            idle_reg <= 1'b1;
            ackph_reg <= 1'b0;
            low_reg <= 1'b0;
        end else begin
            scl_d_reg <= scl_s;
            sda_d_reg <= sda_s;
            cnt_reg <= (tick_w || state_reg == TW_ST_IDLE) ? 8'h00 : cnt_reg + 8'h01;
            idle_reg <= state_reg == TW_ST_IDLE;
            ackph_reg <= state_reg == TW_ST_BITS && ack_bit_w;
            low_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bit engine; target sees start/stop on the bus before anything else
    always_ff @(posedge clk_link_i or negedge link_rst_n) begin
        if (!link_rst_n) begin
            state_reg <= TW_ST_IDLE;
            bitcnt_reg <= 4'h0;
            shreg_reg <= 8'h00;
            rxb_reg <= 8'h00;
            dir_tx_reg <= 1'b0;
            addr_ph_reg <= 1'b0;
            rw_reg <= 1'b0;
            stop_lat_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            take_tgl_reg <= 1'b0;
            rx_tgl_reg <= 1'b0;
            start_tgl_reg <= 1'b0;
            stop_tgl_reg <= 1'b0;
            nack_tgl_reg <= 1'b0;
        end else if (bus_stop_w) begin
            if (state_reg != TW_ST_IDLE) begin
                stop_tgl_reg <= !stop_tgl_reg;
            end
            sda_oe_reg <= 1'b0;
            state_reg <= TW_ST_IDLE;
        end else if (bus_start_w) begin
            start_tgl_reg <= !start_tgl_reg;
            bitcnt_reg <= 4'h0;
            addr_ph_reg <= !cfg_l.skip_address_byte;
            dir_tx_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            state_reg <= TW_ST_BITS;
        end else begin
            unique case (state_reg)
                TW_ST_IDLE: begin
                    scl_oe_reg <= 1'b0;
                    sda_oe_reg <= 1'b0;
                    if (ctl_w && tx_pend_w) begin
                        shreg_reg <= link_txd_w;
                        rw_reg <= link_txd_w[0];
                        take_tgl_reg <= !take_tgl_reg;
                        start_tgl_reg <= !start_tgl_reg;
                        addr_ph_reg <= 1'b1;
                        dir_tx_reg <= 1'b1;
                        sda_oe_reg <= 1'b1;
                        state_reg <= TW_ST_START;
                    end
                end
                TW_ST_START: begin
                    if (tick_w) begin
                        scl_oe_reg <= 1'b1;
                        sda_oe_reg <= !shreg_reg[7];
                        bitcnt_reg <= 4'h0;
                        state_reg <= TW_ST_BITS;
                    end
                end
                TW_ST_BITS: begin
                    if (ctl_w && tick_w) begin
                        scl_oe_reg <= !scl_oe_reg;
                    end
                    if (fall_w) begin
                        // Ack slot: receiver drives, transmitter listens
                        sda_oe_reg <= ack_bit_w ? (!dir_tx_reg && ack_low_w)
                                                : (dir_tx_reg && !shreg_reg[7]);
                    end
                    if (rise_w && !ack_bit_w) begin
                        shreg_reg <= dir_tx_reg ? {shreg_reg[6:0], 1'b1} : rx_byte_w;
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                        stop_lat_reg <= cfg_l.stop_after_next_ack;
                        if (bitcnt_reg == TW_LAST_DATA_BIT && !dir_tx_reg && !addr_ph_reg) begin
                            rxb_reg <= rx_byte_w;
                            rx_tgl_reg <= !rx_tgl_reg;
                        end
                    end else if (rise_w) begin
                        bitcnt_reg <= 4'h0;
                        if (nack_w) begin
                            nack_tgl_reg <= !nack_tgl_reg;
                        end
                        if (addr_ph_reg) begin
                            addr_ph_reg <= 1'b0;
                            dir_tx_reg <= next_tx_w;
                            if (ctl_w && nack_w) begin
                                state_reg <= TW_ST_STOP;
                            end else if (!ctl_w && !addr_hit_w) begin
                                state_reg <= TW_ST_SKIP;
                            end else if (next_tx_w && ctl_w && !tx_pend_w) begin
                                state_reg <= TW_ST_WAIT;
                            end else if (next_tx_w) begin
                                shreg_reg <= link_txd_w;
                                take_tgl_reg <= take_tgl_reg ^ tx_pend_w;
                            end
                        end else if (dir_tx_reg) begin
                            if (nack_w) begin
                                state_reg <= ctl_w ? TW_ST_STOP : TW_ST_SKIP;
                            end else if (ctl_w && stop_lat_reg) begin
                                state_reg <= TW_ST_STOP;
                            end else if (ctl_w && !tx_pend_w) begin
                                state_reg <= TW_ST_WAIT;
                            end else begin
                                // Target keeps resending the buffer as long as each byte is acked
                                shreg_reg <= link_txd_w;
                                take_tgl_reg <= take_tgl_reg ^ tx_pend_w;
                            end
                        end else if (ctl_w && stop_lat_reg) begin
                            state_reg <= TW_ST_STOP;
                        end
                    end
                end
                TW_ST_WAIT: begin
                    // Controller holds the clock low until software supplies a byte or requests a stop
                    if (tick_w && scl_oe_reg == 1'b0) begin
                        scl_oe_reg <= 1'b1;
                    end else if (scl_oe_reg && cfg_l.stop_after_next_ack) begin
                        bitcnt_reg <= 4'h0;
                        state_reg <= TW_ST_STOP;
                    end else if (scl_oe_reg && tx_pend_w) begin
                        shreg_reg <= link_txd_w;
                        take_tgl_reg <= !take_tgl_reg;
                        sda_oe_reg <= !link_txd_w[7];
                        state_reg <= TW_ST_BITS;
                    end
                end
                TW_ST_STOP: begin
                    if (tick_w) begin
                        bitcnt_reg <= bitcnt_reg + 4'h1;
                        // SDA drops only once SCL is low, else the far end sees a start
                        if (bitcnt_reg == 4'h0) begin
                            scl_oe_reg <= 1'b1;
                        end else if (bitcnt_reg == 4'h1) begin
                            sda_oe_reg <= 1'b1;
                        end else if (bitcnt_reg == 4'h2) begin
                            scl_oe_reg <= 1'b0;
                        end else begin
                            sda_oe_reg <= 1'b0;
                            bitcnt_reg <= 4'h0;
                            state_reg <= TW_ST_IDLE;
                        end
                    end
                end
                TW_ST_SKIP: begin
                    sda_oe_reg <= 1'b0;
                    if (ctl_w) begin
                        state_reg <= TW_ST_IDLE;
                    end
                end
                default: begin
                    state_reg <= TW_ST_IDLE;
                end
            endcase
        end
    end

    assign scl_oe_o = scl_oe_reg;
    assign sda_oe_o = sda_oe_reg;
    assign scl_o = low_reg;
    assign sda_o = low_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Processor-side register decode
    wire logic ev_rx = ev_p[4];
    wire logic ev_take = ev_p[3];
    wire logic ev_start = ev_p[2];
    wire logic ev_stop = ev_p[1];
    wire logic ev_nack = ev_p[0];
    wire logic hit_cfg = sfr_addr_i == TW_CONFIG_ADDR;
    wire logic hit_stat = sfr_addr_i == TW_STATUS_ADDR;
    wire logic hit_data = sfr_addr_i == TW_DATA_ADDR;
    wire logic wr_cfg = sfr_wr_i && hit_cfg;
    wire logic wr_data = sfr_wr_i && hit_data;
    wire logic rd_data = sfr_rd_i && hit_data;
    wire logic rd_stat = sfr_rd_i && hit_stat;
    wire logic [7:0] rd_mux = hit_cfg ? cfg_reg :
                              hit_stat ? status_w :
                              hit_data ? rxd_reg : 8'h00;
    wire logic irq_next = (rx_ov_reg && cfg_reg.rx_overrun_irq_en) ||
                          (rx_av_reg && cfg_reg.rx_avail_irq_en) ||
                          (tx_emp_reg && cfg_reg.tx_empty_irq_en);

    // Status view; data line and ack phase are live bus levels
    assign status_w = '{
        stop_seen_flag: stop_seen_reg,
        nack_seen_flag: nack_seen_reg,
        data_line_level: sda_lvl_s,
        ack_phase_flag: lvl_s[0],
        idle_flag: lvl_s[1],
        rx_overrun_flag: rx_ov_reg,
        rx_avail_flag: rx_av_reg,
        tx_empty_flag: tx_emp_reg
    };

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and transmit buffer
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_reg <= TW_CONFIG_RST;
            txd_reg <= TW_DATA_RST;
            tx_req_tgl_reg <= 1'b0;
        end else begin
            if (wr_cfg) begin
                cfg_reg <= sfr_wdata_i;
            end
            if (wr_data) begin
                txd_reg <= sfr_wdata_i;
                tx_req_tgl_reg <= !tx_req_tgl_reg;
            end
        end
    end

    // Sticky flags; a hardware set always beats a clear in the same cycle
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rxd_reg <= TW_DATA_RST;
            rx_av_reg <= 1'b0;
            rx_ov_reg <= 1'b0;
            tx_emp_reg <= TW_TX_EMPTY_RST;
            stop_seen_reg <= 1'b0;
            nack_seen_reg <= 1'b0;
        end else begin
            if (ev_rx) begin
                rxd_reg <= rxb_reg;
            end
            rx_av_reg <= ev_rx || (rx_av_reg && !rd_data);
            rx_ov_reg <= (ev_rx && rx_av_reg) || (rx_ov_reg && !rd_stat);
            tx_emp_reg <= ev_take || (tx_emp_reg && !wr_data);
            stop_seen_reg <= ev_stop || (stop_seen_reg && !ev_start);
            nack_seen_reg <= ev_nack || (nack_seen_reg && !ev_start);
        end
    end

    // Read data and interrupt line, both registered
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_reg <= 8'h00;
            irq_reg <= 1'b0;
        end else begin
            if (sfr_rd_i) begin
                rdata_reg <= rd_mux;
            end
            irq_reg <= irq_next;
        end
    end

    assign sfr_rdata_o = rdata_reg;
    assign irq_o = irq_reg;

endmodule : tw_port

// file: core/tw_pkg.sv
package tw_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Special-function register offsets
    localparam logic [7:0] TW_CONFIG_ADDR = 8'hda;
    localparam logic [7:0] TW_STATUS_ADDR = 8'hdd;
    localparam logic [7:0] TW_DATA_ADDR = 8'hde;

    // Values after reset
    localparam logic [7:0] TW_CONFIG_RST = 8'h00;
    localparam logic [7:0] TW_DATA_RST = 8'h00;
    localparam logic TW_TX_EMPTY_RST = 1'b1;

    // Bit position of the acknowledge slot within a byte frame
    localparam logic [3:0] TW_ACK_BIT = 4'h8;
    localparam logic [3:0] TW_LAST_DATA_BIT = 4'h7;

    // Own target address, arbitrary value
    localparam logic [6:0] TW_OWN_ID = 7'h2a;

    ////////////////////////////////////////////////////////////////////////////
    // Serial clock timing, counted on the link clock
    localparam int TW_LINK_PERIOD_NS = 30;
    localparam int TW_SCL_PERIOD_NS = 10000;
    localparam int TW_HALF_CYC_INT = (TW_SCL_PERIOD_NS / 2) / TW_LINK_PERIOD_NS;
    localparam logic [7:0] TW_HALF_CYC = 8'((TW_HALF_CYC_INT > 0) ? TW_HALF_CYC_INT : 1);

    ////////////////////////////////////////////////////////////////////////////
    // Register layouts, most significant field first
    typedef struct packed {
        logic skip_address_byte;
        logic rx_overrun_irq_en;
        logic rx_avail_irq_en;
        logic tx_empty_irq_en;
        logic ack_level_select;
        logic manual_ack_enable;
        logic stop_after_next_ack;
        logic controller_role_select;
    } tw_cfg_t;

    typedef struct packed {
        logic stop_seen_flag;
        logic nack_seen_flag;
        logic data_line_level;
        logic ack_phase_flag;
        logic idle_flag;
        logic rx_overrun_flag;
        logic rx_avail_flag;
        logic tx_empty_flag;
    } tw_status_t;

    // Bit engine states
    typedef enum logic [2:0] {
        TW_ST_IDLE = 3'b000,
        TW_ST_START = 3'b001,
        TW_ST_BITS = 3'b010,
        TW_ST_WAIT = 3'b011,
        TW_ST_STOP = 3'b100,
        TW_ST_SKIP = 3'b101
    } tw_state_t;

endpackage : tw_pkg

// file: core/tw_sync.sv
`timescale 1ns/1ps
// Two-stage level synchroniser
module tw_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_reg;

    // First stage feeds only the second
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            q_o <= '0;
        end else begin
            meta_reg <= d_i;
            q_o <= meta_reg;
        end
    end

endmodule : tw_sync

// file: core/tw_evt.sv
`timescale 1ns/1ps
// Toggle-to-pulse event crossing
module tw_evt #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [W-1:0] tgl_i,
    output logic [W-1:0] pulse_o
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;
    logic [W-1:0] last_reg;

    // Edge detect only looks past the first stage
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            sync_reg <= '0;
            last_reg <= '0;
        end else begin
            meta_reg <= tgl_i;
            sync_reg <= meta_reg;
            last_reg <= sync_reg;
        end
    end

    assign pulse_o = sync_reg ^ last_reg;

endmodule : tw_evt

// file: sim/tw_port_asserts.sv
`timescale 1ns/1ps
module tw_port_asserts
    import tw_pkg::*;
(
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic clk_link_i,
    input wire logic [7:0] sfr_addr_i,
    input wire logic sfr_wr_i,
    input wire logic sfr_rd_i,
    input wire logic [7:0] sfr_wdata_i,
    input wire logic [7:0] sfr_rdata_o,
    input wire logic irq_o,
    input wire logic scl_i,
    input wire logic scl_o,
    input wire logic scl_oe_o,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe_o
);
    logic [7:0] cfg_reg;
    // Access decode
    wire map_hit = sfr_addr_i inside {TW_CONFIG_ADDR, TW_STATUS_ADDR, TW_DATA_ADDR};
    wire st_rd = sfr_rd_i && sfr_addr_i == TW_STATUS_ADDR;
    wire dat_rd = sfr_rd_i && sfr_addr_i == TW_DATA_ADDR;
    wire dat_wr = sfr_wr_i && sfr_addr_i == TW_DATA_ADDR;
    wire cfg_rd = sfr_rd_i && sfr_addr_i == TW_CONFIG_ADDR;
    // Shadow of config, so readback is judged from the writes alone
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_reg <= TW_CONFIG_RST;
        end else if (sfr_wr_i && sfr_addr_i == TW_CONFIG_ADDR) begin
            cfg_reg <= sfr_wdata_i;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    a_open_drain_zero: assert property (!scl_o && !sda_o)
        else $error("pin value not zero");
    a_unmapped_zero: assert property (sfr_rd_i && !map_hit |=> sfr_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!sfr_rd_i |=> $stable(sfr_rdata_o))
        else $error("read data moved without read");
    a_config_readback: assert property (cfg_rd |=> sfr_rdata_o == $past(cfg_reg))
        else $error("config readback wrong");
    a_irq_disabled: assert property (cfg_reg[6:4] == 3'h0 [*3] |-> !irq_o)
        else $error("irq with all enables off");
    a_tx_empty_clear: assert property (dat_wr ##2 st_rd |=> !sfr_rdata_o[0])
        else $error("tx empty not cleared by write");
    a_rx_avail_clear: assert property (dat_rd ##2 st_rd |=> !sfr_rdata_o[1])
        else $error("rx avail not cleared by read");
    a_target_no_clock: assert property (!cfg_reg[0] [*4] |-> !scl_oe_o)
        else $error("target drives clock");
    a_scl_high_min: assert property ($fell(scl_oe_o) |-> !scl_oe_o [*8])
        else $error("clock high too short");
    c_irq_raised: cover property ($rose(irq_o));
    c_controller_clock: cover property ($fell(scl_oe_o));
    c_nack_read: cover property (st_rd ##1 sfr_rdata_o[6]);
    c_rx_avail_read: cover property (st_rd ##1 sfr_rdata_o[1]);
endmodule : tw_port_asserts
bind tw_port tw_port_asserts i_chk (.clk_i, .arst_n_i, .clk_link_i, .sfr_addr_i, .sfr_wr_i,
    .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .irq_o, .scl_i, .scl_o, .scl_oe_o, .sda_i, .sda_o,
    .sda_oe_o);

// file: sim/tw_bus_model.sv
`timescale 1ns/1ps
module tw_bus_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [7:0] tdat_i,
    output logic sda_oe_o
);
    int cnt;
    logic [7:0] sh;
    logic busy = 1'b0;
    logic first;
    logic hit;
    logic rd;
    logic go = 1'b0;
    initial sda_oe_o = 1'b0;
    // Start; the delay filters data that moves right at the clock fall
    always @(negedge sda_i) begin
        #1;
        if (scl_i) begin
            busy = 1'b1;
            first = 1'b1;
            go = 1'b0;
            cnt = -1;
        end
    end
    // Stop
    always @(posedge sda_i) begin
        #1;
        if (scl_i) busy = 1'b0;
    end
    // Shift in msb first on clock rise
    always @(posedge scl_i) begin
        if (busy) sh = {sh[6:0], sda_i};
    end
    // Ack when addressed and receiving; on a read, send tdat_i msb first while acked
    always @(negedge scl_i) begin
        if (busy) begin
            cnt = cnt + 1;
            if (cnt == 8) begin
                hit = first ? (sh[7:1] == ADDR) : hit;
                rd = first ? sh[0] : rd;
                sda_oe_o = hit && (first || !rd);
                first = 1'b0;
            end else if (cnt == 9) begin
                cnt = 0;
                go = hit && rd && !sh[0];
                sda_oe_o = go && !tdat_i[7];
            end else begin
                sda_oe_o = go && !tdat_i[7 - cnt];
            end
        end
    end
endmodule : tw_bus_model

// file: sim/tw_port_tb.sv
`timescale 1ns/1ps
module tw_port_tb;
    import tw_pkg::*;
    logic clk_i = 1'b0;
    logic clk_link_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic [7:0] sfr_addr_i = 8'h00;
    logic sfr_wr_i = 1'b0;
    logic sfr_rd_i = 1'b0;
    logic [7:0] sfr_wdata_i = 8'h00;
    logic [7:0] sfr_rdata_o, rv, v;
    logic irq_o, scl_oe_o, sda_oe_o, peer_oe;
    logic [31:0] seed = 32'h3f;
    int errors = 0;
    int checks = 0;
    // Open-drain wires with pull-ups
    wire scl = !scl_oe_o;
    wire sda = !(sda_oe_o || peer_oe);
    always #2.5 clk_i = !clk_i;
    initial begin
        #3.1;
        forever #15 clk_link_i = !clk_link_i;
    end
    tw_port i_dut (.clk_i, .arst_n_i, .clk_link_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i,
        .sfr_wdata_i, .sfr_rdata_o, .irq_o, .scl_i(scl), .scl_o(), .scl_oe_o,
        .sda_i(sda), .sda_o(), .sda_oe_o);
    tw_bus_model i_peer (.scl_i(scl), .sda_i(sda), .tdat_i(v), .sda_oe_o(peer_oe));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : chk
    // One register access, strobe held for exactly one edge
    task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        sfr_addr_i = a;
        sfr_wdata_i = d;
        sfr_wr_i = w;
        sfr_rd_i = !w;
        @(posedge clk_i);
        #1;
        sfr_wr_i = 1'b0;
        sfr_rd_i = 1'b0;
        rv = sfr_rdata_o;
    endtask : acc
    task automatic wait_bit(input int b, input logic val);
        int n;
        n = 0;
        do begin
            acc(TW_STATUS_ADDR, 1'b0, 8'h00);
            n++;
        end while (rv[b] !== val && n < 30000);
        chk("status bit", {7'h00, val}, {7'h00, rv[b]});
    endtask : wait_bit
    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : results
    initial begin
        repeat (6) @(posedge clk_i);
        #1;
        arst_n_i = 1'b1;
        repeat (40) @(posedge clk_i);
        acc(TW_CONFIG_ADDR, 1'b0, 8'h00);
        chk("config", TW_CONFIG_RST, rv);
        acc(TW_STATUS_ADDR, 1'b1, 8'hff);
        acc(8'h00, 1'b0, 8'h00);
        chk("unmapped", 8'h00, rv);
        acc(TW_DATA_ADDR, 1'b0, 8'h00);
        chk("data", TW_DATA_RST, rv);
        acc(TW_STATUS_ADDR, 1'b0, 8'h00);
        chk("status", 8'h29, rv);
        $display("reset test done");
        // Random enables in target role; only tx empty is set, so it alone drives irq
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            v = seed[7:0] & 8'hfe;
            acc(TW_CONFIG_ADDR, 1'b1, v);
            acc(TW_CONFIG_ADDR, 1'b0, 8'h00);
            chk("config", v, rv);
            repeat (3) @(posedge clk_i);
            #1;
            chk("irq", {7'h00, v[4]}, {7'h00, irq_o});
        end
        $display("config test done");
        acc(TW_CONFIG_ADDR, 1'b1, 8'h01);
        acc(TW_DATA_ADDR, 1'b1, 8'ha0);
        wait_bit(3, 1'b0);
        acc(TW_CONFIG_ADDR, 1'b1, 8'h03);
        wait_bit(3, 1'b1);
        chk("nack", 8'h00, rv & 8'h40);
        acc(TW_CONFIG_ADDR, 1'b1, 8'h01);
        acc(TW_DATA_ADDR, 1'b1, 8'h66);
        wait_bit(3, 1'b0);
        wait_bit(3, 1'b1);
        chk("nack", 8'h40, rv & 8'h40);
        chk("tx empty", 8'h01, rv & 8'h01);
        $display("controller test done");
        // Controller read of one random byte; stop bit set, so the byte gets a NACK
        seed = xs(seed);
        v = seed[15:8];
        acc(TW_CONFIG_ADDR, 1'b1, 8'h23);
        acc(TW_DATA_ADDR, 1'b1, 8'ha1);
        wait_bit(3, 1'b0);
        wait_bit(3, 1'b1);
        chk("rx avail", 8'h02, rv & 8'h42);
        chk("irq", 8'h01, {7'h00, irq_o});
        acc(TW_DATA_ADDR, 1'b0, 8'h00);
        chk("rx data", v, rv);
        acc(TW_STATUS_ADDR, 1'b0, 8'h00);
        chk("rx avail", 8'h00, rv & 8'h02);
        chk("irq", 8'h00, {7'h00, irq_o});
        $display("read test done");
        results();
    end
    // Three bus transactions take about 440 us
    initial begin
        #480000;
        errors++;
        results();
    end
endmodule : tw_port_tb
